// ---- logic/rgc_axil_slave.sv ----
// AXI4-Lite slave front end: single-beat write and read handshakes
`include "rgc_consts.svh"
module rgc_axil_slave
  import rgc_pkg::*;
#(
  parameter int ADDR_W = `RGC_ADDR_W
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_stb,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [7:0]             wr_data,
  input  wire logic              wr_ok,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_ok
);
  logic              aw_have, next_aw_have, w_have, next_w_have;
  logic [ADDR_W-1:0] aw_q, next_aw_q;
  logic [7:0]        w_q, next_w_q;
  logic              w_en, next_w_en;
  logic              bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]        bresp, next_bresp, rresp, next_rresp;
  logic [31:0]       rdata, next_rdata;
  logic              go_wr, go_rd;
  logic              aw_rdy, next_aw_rdy, w_rdy, next_w_rdy;
  logic              ar_rdy, next_ar_rdy;

  // ready flags are registered copies of the slot state
  assign s_axi_awready = aw_rdy;
  assign s_axi_wready  = w_rdy;
  assign s_axi_arready = ar_rdy;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;
  assign wr_addr       = aw_q;
  assign wr_data       = w_q;
  assign rd_addr       = s_axi_araddr;
  assign go_wr         = aw_have & w_have & ~bvalid;
  assign go_rd         = s_axi_arvalid & ~rvalid;
  // only byte lane 0 carries implemented bits; others are dropped
  assign wr_stb        = go_wr & w_en;

  always_comb
  begin
    next_aw_have = aw_have;
    next_aw_q    = aw_q;
    next_w_have  = w_have;
    next_w_q     = w_q;
    next_w_en    = w_en;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_have = 1'b1;
      next_aw_q    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_have = 1'b1;
      next_w_q    = s_axi_wdata[7:0];
      next_w_en   = s_axi_wstrb[0];
    end
    if (go_wr)
    begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_ok ? `RGC_RESP_OKAY : `RGC_RESP_SLVERR;
    end
    else if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (go_rd)
    begin
      next_rvalid = 1'b1;
      next_rresp  = rd_ok ? `RGC_RESP_OKAY : `RGC_RESP_SLVERR;
      next_rdata  = {24'h000000, rd_data};
    end
    else if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    next_aw_rdy = ~next_aw_have & ~next_bvalid;
    next_w_rdy  = ~next_w_have & ~next_bvalid;
    next_ar_rdy = ~next_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have <= 1'b0;
      aw_q    <= '0;
      w_have  <= 1'b0;
      w_q     <= `RGC_RST_BYTE;
      w_en    <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RGC_RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= `RGC_RESP_OKAY;
      rdata   <= 32'h00000000;
      aw_rdy  <= 1'b1;
      w_rdy   <= 1'b1;
      ar_rdy  <= 1'b1;
    end
    else
    begin
      aw_have <= next_aw_have;
      aw_q    <= next_aw_q;
      w_have  <= next_w_have;
      w_q     <= next_w_q;
      w_en    <= next_w_en;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      aw_rdy  <= next_aw_rdy;
      w_rdy   <= next_w_rdy;
      ar_rdy  <= next_ar_rdy;
    end
  end

  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    go_wr |=> bvalid)
    else $error("write response missing after accept");
  chk_read_zero: assert property (@(posedge aclk)
    disable iff (!aresetn) go_rd |=> rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
endmodule : rgc_axil_slave

// ---- logic/rgc_consts.svh ----
// register offsets, field positions, reset values and timing constants
`ifndef RGC_CONSTS_SVH
`define RGC_CONSTS_SVH
`define RGC_OFF_MAIN      4'h0
`define RGC_OFF_STATPOL   4'h4
`define RGC_OFF_VSEL      4'h8
`define RGC_OFF_CURRENT_CODE      4'hc
`define RGC_OFF_RSRC      4'h0
`define RGC_OFF_FSRC      4'h4
`define RGC_ADDR_W        5
`define RGC_BIT_EN        7
`define RGC_BIT_FALL_EDGE_SELECT      5
`define RGC_BIT_RISE_EDGE_SELECT      4
`define RGC_BIT_MODE_HI   3
`define RGC_BIT_MODE_LO   2
`define RGC_BIT_OS        1
`define RGC_BIT_GO        0
`define RGC_BIT_RDY       2
`define RGC_BIT_FALL_INPUT_POLARITY      1
`define RGC_BIT_RISE_INPUT_POLARITY      0
`define RGC_RST_BYTE      8'h00
`define RGC_MASK_MAIN     8'hbf
`define RGC_MASK_POL      8'h03
`define RGC_MASK_NIB      8'h0f
`define RGC_MASK_CURRENT_CODE     8'h1f
`define RGC_VSEL_SW0      4'h8
`define RGC_VSEL_SW1      4'h9
`define RGC_VSEL_RES7     4'h7
`define RGC_VSEL_MAXOK    4'h9
`define RGC_SRC_CMP_MAX   4'h3
`define RGC_SRC_PIN       4'h7
`define RGC_SRC_PWM_MIN   4'h8
`define RGC_SRC_PWM_MAX   4'ha
`define RGC_CLK_HZ        25000000
`define RGC_READY_NS      1000
`define RGC_ONESHOT_NS    50
`define RGC_RESP_OKAY     2'b00
`define RGC_RESP_SLVERR   2'b10
`endif

// ---- logic/rgc_pkg.sv ----
// types shared by the ramp generator control block
package rgc_pkg;
  typedef enum logic [1:0] {
    RGC_MODE_SLOPE,
    RGC_MODE_ALT,
    RGC_MODE_RISE,
    RGC_MODE_RSVD
  } rgc_mode_t;
  typedef enum logic [1:0] {
    RGC_SRC_CMP,
    RGC_SRC_PIN,
    RGC_SRC_PWM,
    RGC_SRC_NONE
  } rgc_src_t;
endpackage : rgc_pkg

// ---- logic/rgc_ramp_ctrl.sv ----
// ramp generator control: registers, timing inputs and switch control
`include "rgc_consts.svh"
module rgc_ramp_ctrl
  import rgc_pkg::*;
#(
  parameter int CLK_HZ      = `RGC_CLK_HZ,
  parameter int READY_NS    = `RGC_READY_NS,
  parameter int ONESHOT_NS  = `RGC_ONESHOT_NS
)
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`RGC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`RGC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [3:0]             cmp_sync,
  input  wire logic [2:0]             pwm_out,
  input  wire logic                   rise_pin,
  input  wire logic                   fall_pin,
  input  wire logic                   opamp_tristate,
  output logic                        analog_enable,
  output logic                        source_switch,
  output logic                        sink_switch,
  output logic                        discharge_switch,
  output logic [3:0]                  start_voltage_select,
  output logic                        start_voltage_connect,
  output logic [4:0]                  current_code,
  output logic [1:0]                  ramp_mode
);
  // least times round up to whole cycles
  localparam int READY_CYC =
    (READY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int OS_CYC0 =
    (ONESHOT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int OS_CYC = (OS_CYC0 < 1) ? 1 : OS_CYC0;

  logic [`RGC_ADDR_W-1:0] wr_addr, rd_addr;
  logic       wr_stb, wr_ok, rd_ok;
  logic [7:0] wr_data, rd_data;
  logic [7:0] main_r, next_main;
  logic [1:0] pol_r, next_pol;
  logic [3:0] vsel_r, next_vsel, rsrc_r, next_rsrc, fsrc_r, next_fsrc;
  logic [4:0] current_code_r, next_current_code;
  logic [9:0] rdy_cnt, next_rdy_cnt;
  logic       ready, next_ready;
  logic [3:0] os_cnt, next_os_cnt;
  logic       go_prev, next_go_prev;
  logic       rising, next_rising;
  logic       rise_ev, fall_ev, en, go, os_en, os_busy;
  logic       o_en, o_src, o_snk, o_dis, o_conn;
  logic       next_o_src, next_o_snk, next_o_dis, next_o_conn;
  rgc_mode_t  mode;

  assign en      = main_r[`RGC_BIT_EN];
  assign go      = main_r[`RGC_BIT_GO];
  assign os_en   = main_r[`RGC_BIT_OS];
  assign mode    = rgc_mode_t'(main_r[`RGC_BIT_MODE_HI:`RGC_BIT_MODE_LO]);
  assign os_busy = os_cnt != 4'h0;

  rgc_axil_slave #(.ADDR_W(`RGC_ADDR_W)) u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ok(wr_ok),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
  );

  // the one-shot suppresses inputs; level inputs resume after it
  rgc_timing_input u_rise (
    .aclk(aclk), .aresetn(aresetn), .cmp_in(cmp_sync), .pin_in(rise_pin),
    .pwm_in(pwm_out), .src_code(rsrc_r), .active_low(pol_r[`RGC_BIT_RISE_INPUT_POLARITY]),
    .edge_mode(main_r[`RGC_BIT_RISE_EDGE_SELECT]), .armed(en & ~os_busy),
    .event_out(rise_ev)
  );
  rgc_timing_input u_fall (
    .aclk(aclk), .aresetn(aresetn), .cmp_in(cmp_sync), .pin_in(fall_pin),
    .pwm_in(pwm_out), .src_code(fsrc_r), .active_low(pol_r[`RGC_BIT_FALL_INPUT_POLARITY]),
    .edge_mode(main_r[`RGC_BIT_FALL_EDGE_SELECT]), .armed(en & ~os_busy),
    .event_out(fall_ev)
  );

  // register decode; bank 1 (addr bit 4) holds the source selects
  always_comb
  begin
    next_main = main_r;
    next_pol  = pol_r;
    next_vsel = vsel_r;
    next_current_code = current_code_r;
    next_rsrc = rsrc_r;
    next_fsrc = fsrc_r;
    wr_ok = 1'b1;
    if (wr_stb)
    begin
      unique case ({wr_addr[4], wr_addr[3:0]})
        {1'b0, `RGC_OFF_MAIN}:    next_main = wr_data & `RGC_MASK_MAIN;
        {1'b0, `RGC_OFF_STATPOL}: next_pol  = wr_data[1:0];
        {1'b0, `RGC_OFF_VSEL}:    next_vsel = wr_data[3:0];
        {1'b0, `RGC_OFF_CURRENT_CODE}:    next_current_code = wr_data[4:0];
        {1'b1, `RGC_OFF_RSRC}:    next_rsrc = wr_data[3:0];
        {1'b1, `RGC_OFF_FSRC}:    next_fsrc = wr_data[3:0];
        default:                  wr_ok = 1'b0;
      endcase
    end
    if (!next_main[`RGC_BIT_EN])
      next_main[`RGC_BIT_GO] = 1'b0;
    rd_ok   = 1'b1;
    rd_data = 8'h00;
    unique case ({rd_addr[4], rd_addr[3:0]})
      {1'b0, `RGC_OFF_MAIN}:    rd_data = main_r;
      {1'b0, `RGC_OFF_STATPOL}: rd_data = {5'h00, ready, pol_r};
      {1'b0, `RGC_OFF_VSEL}:    rd_data = {4'h0, vsel_r};
      {1'b0, `RGC_OFF_CURRENT_CODE}:    rd_data = {3'h0, current_code_r};
      {1'b1, `RGC_OFF_RSRC}:    rd_data = {4'h0, rsrc_r};
      {1'b1, `RGC_OFF_FSRC}:    rd_data = {4'h0, fsrc_r};
      default:                  rd_ok = 1'b0;
    endcase
  end

  // ready settles after enable; software waits on it before start
  always_comb
  begin
    next_rdy_cnt = rdy_cnt;
    next_ready   = ready;
    if (!en)
    begin
      next_rdy_cnt = 10'h000;
      next_ready   = 1'b0;
    end
    else if (!ready)
    begin
      next_rdy_cnt = rdy_cnt + 10'h001;
      next_ready   = (rdy_cnt == 10'(READY_CYC - 1));
    end
  end

  // ramp direction and one-shot; falling input dominates rising
  always_comb
  begin
    next_go_prev = go;
    next_os_cnt  = os_busy ? os_cnt - 4'h1 : 4'h0;
    next_rising  = rising;
    if (go && !go_prev && os_en)
      next_os_cnt = 4'(OS_CYC);
    if (!go)
      next_rising = 1'b0;
    else if (fall_ev)
    begin
      next_rising = 1'b0;
      if (os_en)
        next_os_cnt = 4'(OS_CYC);
    end
    else if (rise_ev)
    begin
      next_rising = 1'b1;
      // in slope and rising modes the one-shot only times discharge
      if (os_en && mode == RGC_MODE_ALT)
        next_os_cnt = 4'(OS_CYC);
    end
  end

  always_comb
  begin
    next_o_src  = 1'b0;
    next_o_snk  = 1'b0;
    next_o_dis  = 1'b1;
    if (en && go && !(go && !go_prev && os_en))
    begin
      unique case (mode)
        RGC_MODE_ALT:
        begin
          next_o_src = next_rising;
          next_o_snk = ~next_rising;
          next_o_dis = 1'b0;
        end
        RGC_MODE_SLOPE, RGC_MODE_RISE:
        begin
          // discharge holds from a falling event until the next rising event
          next_o_src = next_rising & (mode == RGC_MODE_RISE);
          next_o_snk = next_rising & (mode == RGC_MODE_SLOPE);
          next_o_dis = ~next_rising | (os_busy & os_en);
        end
        RGC_MODE_RSVD: next_o_dis = 1'b1;
      endcase
    end
    next_o_conn = !(opamp_tristate &&
      (vsel_r == `RGC_VSEL_SW0 || vsel_r == `RGC_VSEL_SW1)) &&
      vsel_r != `RGC_VSEL_RES7 && vsel_r <= `RGC_VSEL_MAXOK;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_r  <= `RGC_RST_BYTE;
      pol_r   <= 2'h0;
      vsel_r  <= 4'h0;
      current_code_r  <= 5'h00;
      rsrc_r  <= 4'h0;
      fsrc_r  <= 4'h0;
      rdy_cnt <= 10'h000;
      ready   <= 1'b0;
      os_cnt  <= 4'h0;
      go_prev <= 1'b0;
      rising  <= 1'b0;
      o_en    <= 1'b0;
      o_src   <= 1'b0;
      o_snk   <= 1'b0;
      o_dis   <= 1'b1;
      o_conn  <= 1'b0;
    end
    else
    begin
      main_r  <= next_main;
      pol_r   <= next_pol;
      vsel_r  <= next_vsel;
      current_code_r  <= next_current_code;
      rsrc_r  <= next_rsrc;
      fsrc_r  <= next_fsrc;
      rdy_cnt <= next_rdy_cnt;
      ready   <= next_ready;
      os_cnt  <= next_os_cnt;
      go_prev <= next_go_prev;
      rising  <= next_rising;
      o_en    <= next_main[`RGC_BIT_EN];
      o_src   <= next_o_src;
      o_snk   <= next_o_snk;
      o_dis   <= next_o_dis;
      o_conn  <= next_o_conn;
    end
  end

  assign analog_enable         = o_en;
  assign source_switch         = o_src;
  assign sink_switch           = o_snk;
  assign discharge_switch      = o_dis;
  assign start_voltage_select  = vsel_r;
  assign start_voltage_connect = o_conn;
  assign current_code          = current_code_r;
  assign ramp_mode             = main_r[`RGC_BIT_MODE_HI:`RGC_BIT_MODE_LO];

  sequence s_start_edge;
    go && !go_prev && os_en;
  endsequence
  chk_go_forced_low: assert property (@(posedge aclk)
    disable iff (!aresetn) !en |-> !go)
    else $error("start set while disabled");
  chk_stop_switches: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !go |=> discharge_switch && !source_switch && !sink_switch)
    else $error("switches not safe while stopped");
  chk_oneshot_hold: assert property (@(posedge aclk)
    disable iff (!aresetn) s_start_edge |=> discharge_switch && os_busy)
    else $error("one-shot not started on start edge");
  chk_enable_out: assert property (@(posedge aclk)
    disable iff (!aresetn) analog_enable == en)
    else $error("enable output mismatch");
  chk_ready_low: assert property (@(posedge aclk)
    disable iff (!aresetn) !en |=> !ready)
    else $error("ready high while disabled");
  chk_switched_off: assert property (@(posedge aclk)
    disable iff (!aresetn)
    opamp_tristate && vsel_r == `RGC_VSEL_SW0 |=> !start_voltage_connect)
    else $error("switched input not disconnected");
  chk_alt_drive: assert property (@(posedge aclk)
    disable iff (!aresetn)
    source_switch |-> !sink_switch && !discharge_switch)
    else $error("source on with sink or discharge");
  chk_unimpl_zero: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (main_r & ~`RGC_MASK_MAIN) == 8'h00 && current_code_r == current_code)
    else $error("unimplemented bit set");
endmodule : rgc_ramp_ctrl

// ---- logic/rgc_timing_input.sv ----
// one timing input: source select, polarity, edge or level detection
`include "rgc_consts.svh"
module rgc_timing_input
  import rgc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] cmp_in,
  input  wire logic       pin_in,
  input  wire logic [2:0] pwm_in,
  input  wire logic [3:0] src_code,
  input  wire logic       active_low,
  input  wire logic       edge_mode,
  input  wire logic       armed,
  output logic            event_out
);
  logic     raw;
  logic     pol;
  logic     prev;
  logic     next_prev;
  rgc_src_t kind;

  always_comb
  begin
    kind = RGC_SRC_NONE;
    if (src_code <= `RGC_SRC_CMP_MAX)
      kind = RGC_SRC_CMP;
    else if (src_code == `RGC_SRC_PIN)
      kind = RGC_SRC_PIN;
    else if (src_code >= `RGC_SRC_PWM_MIN && src_code <= `RGC_SRC_PWM_MAX)
      kind = RGC_SRC_PWM;
    unique case (kind)
      RGC_SRC_CMP: raw = cmp_in[src_code[1:0]];
      RGC_SRC_PIN: raw = pin_in;
      RGC_SRC_PWM: raw = pwm_in[2'(src_code - `RGC_SRC_PWM_MIN)];
      RGC_SRC_NONE: raw = 1'b0;
    endcase
    pol = raw ^ active_low;
    // track the level while disarmed too: a level held through the
    // one-shot must not count as a fresh edge afterwards
    next_prev = pol;
    // edge: clocked compare against last cycle's level
    event_out = armed & (edge_mode ? (pol & ~prev) : pol);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev <= 1'b0;
    else
      prev <= next_prev;
  end
endmodule : rgc_timing_input

// ---- testbench/rgc_ramp_ctrl_test.sv ----
// self-checking bench for the ramp generator control block
module rgc_ramp_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, cmp;
  logic        rise_pin, opa_ts, an_en, src_sw, snk_sw, dis_sw, v_conn;
  logic [4:0]  awaddr, araddr, cur;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, v_sel;
  logic [1:0]  bresp, rresp, mode;
  int          failures, total_checks;
  localparam logic [1:0] OK = 2'b00;

  rgc_ramp_ctrl i_rgc_ramp_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmp_sync({3'h0, cmp}), .pwm_out(3'h0), .rise_pin(rise_pin),
    .fall_pin(1'b0), .opamp_tristate(opa_ts), .analog_enable(an_en),
    .source_switch(src_sw), .sink_switch(snk_sw),
    .discharge_switch(dis_sw), .start_voltage_select(v_sel),
    .start_voltage_connect(v_conn), .current_code(cur), .ramp_mode(mode)
  );

  rgc_ramp_model i_rgc_ramp_model (
    .aclk(aclk), .analog_enable(an_en), .source_switch(src_sw),
    .sink_switch(snk_sw), .discharge_switch(dis_sw), .cmp_out(cmp)
  );

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task hang;
    failures++;
    $display("unexpected at %0t: wait timed out", $time);
    conclude();
  endtask : hang

  task chk_data(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_data

  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: resp %b want %b", $time, got, exp);
    end
  endtask : chk_resp

  // write and read hold each channel until its own handshake edge
  task axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        done = 1'b1;
        bready <= 1'b0;
        chk_resp(bresp, er);
      end
    end
    if (!done)
      hang();
  endtask : axw

  task axr(input logic [4:0] a, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        done = 1'b1;
        rd = rdata;
        rready <= 1'b0;
        chk_resp(rresp, er);
      end
    end
    if (!done)
      hang();
  endtask : axr

  task rdchk(input logic [4:0] a, input logic [31:0] exp);
    axr(a, OK);
    chk_data(rd, exp);
  endtask : rdchk

  // order is source, sink, discharge
  task wait_sw(input logic [2:0] want);
    for (int n = 0; n < 60 && {src_sw, snk_sw, dis_sw} !== want; n++)
      @(posedge aclk);
    if ({src_sw, snk_sw, dis_sw} !== want)
      hang();
    chk_data(32'({src_sw, snk_sw, dis_sw}), 32'(want));
  endtask : wait_sw

  task test_reset;
    for (int i = 0; i < 6; i++)
      rdchk(5'(4 * i), 32'h00000000);
    chk_data(32'(dis_sw), 32'h00000001);
    $display("test reset done");
  endtask : test_reset

  task test_fields;
    logic [7:0] exp [5] = '{8'h3e, 8'h03, 8'h0f, 8'h1f, 8'h0f};
    for (int i = 0; i < 5; i++)
    begin
      axw(5'(4 * i), (i == 0) ? 8'h7f : 8'hff, OK);
      rdchk(5'(4 * i), 32'(exp[i]));
    end
    chk_data(32'(cur), 32'h0000001f);
    wstrb <= 4'he;
    axw(5'h0c, 8'h00, OK);
    wstrb <= 4'hf;
    chk_data(32'(cur), 32'h0000001f);
    chk_data(32'(v_sel), 32'h0000000f);
    chk_data(32'(an_en), 32'h00000000);
    axw(5'h18, 8'h5a, 2'b10);
    axr(5'h18, 2'b10);
    for (int m = 0; m < 4; m++)
    begin
      axw(5'h00, {4'h0, 2'(m), 2'b00}, OK);
      chk_data(32'(mode), 32'(m));
    end
    $display("test fields done");
  endtask : test_fields

  task test_vsel;
    logic [3:0] codes [5] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'ha};
    logic       e;
    for (int i = 0; i < 5; i++)
      for (int t = 0; t < 2; t++)
      begin
        axw(5'h08, {4'h0, codes[i]}, OK);
        opa_ts <= t[0];
        repeat (3) @(posedge aclk);
        e = !(codes[i] == 4'h7 || codes[i] > 4'h9 ||
              (codes[i][3:1] == 3'h4 && t[0]));
        chk_data(32'(v_conn), 32'(e));
      end
    $display("test voltage select done");
  endtask : test_vsel

  task test_ramp;
    axw(5'h04, 8'h01, OK);
    axw(5'h10, 8'h07, OK);
    axw(5'h00, 8'h98, OK);
    chk_data(32'(an_en), 32'h00000001);
    for (int n = 0; n < 20 && rd[2] !== 1'b1; n++)
      axr(5'h04, OK);
    chk_data(rd, 32'h00000005);
    wait_sw(3'b001);
    axw(5'h00, 8'h99, OK);
    rdchk(5'h00, 32'h00000099);
    rise_pin <= 1'b0;
    wait_sw(3'b100);
    rise_pin <= 1'b1;
    wait_sw(3'b001);
    axw(5'h00, 8'h01, OK);
    rdchk(5'h00, 32'h00000000);
    chk_data(32'(an_en), 32'h00000000);
    wait_sw(3'b001);
    $display("test ramp done");
  endtask : test_ramp

  // alternating ramp with one-shot, level inputs, comparator falls
  task test_alt;
    axw(5'h00, 8'h86, OK);
    for (int n = 0; n < 20 && rd[2] !== 1'b1; n++)
      axr(5'h04, OK);
    chk_data(rd, 32'h00000005);
    axw(5'h00, 8'h87, OK);
    @(posedge aclk);
    chk_data(32'({src_sw, snk_sw, dis_sw}), 32'h00000001);
    wait_sw(3'b010);
    rise_pin <= 1'b0;
    wait_sw(3'b100);
    wait_sw(3'b010);
    rise_pin <= 1'b1;
    axw(5'h00, 8'h00, OK);
    wait_sw(3'b001);
    chk_data(32'(an_en), 32'h00000000);
    $display("test alternating done");
  endtask : test_alt

  initial
  begin
    failures = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, opa_ts} = 6'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    rd = 32'h00000000;
    // idle level of an active-low rise input
    rise_pin = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_fields();
    test_vsel();
    test_ramp();
    test_alt();
    conclude();
  end
endmodule : rgc_ramp_ctrl_test

// ---- testbench/rgc_ramp_model.sv ----
// behavioural ramp capacitor with a threshold comparator
module rgc_ramp_model
#(
  parameter int THRESH = 20
)
(
  input  wire logic aclk,
  input  wire logic analog_enable,
  input  wire logic source_switch,
  input  wire logic sink_switch,
  input  wire logic discharge_switch,
  output logic      cmp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int level = 0;
  // shorted or unpowered capacitor holds no charge
  always @(posedge aclk)
    if (!analog_enable || discharge_switch)
      level <= 0;
    else if (source_switch)
      level <= level + 1;
    else if (sink_switch && level > 0)
      level <= level - 1;
  assign cmp_out = analog_enable && level >= THRESH;
endmodule : rgc_ramp_model
